// ---- pmc_params.svh ----
// Register offsets, field positions, masks, reset values and current codes
// for the regulator set-point and charger control block.
// Included by the package and the design file.
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

`define PMC_OFF_LDO 12'h000
`define PMC_OFF_CHG 12'h004
`define PMC_OFF_STAT 12'h008
`define PMC_OFF_CMD 12'h00C

// Regulator control word layout.
`define PMC_LDO1_LSB 0
`define PMC_LDO2_LSB 2
`define PMC_LDO3_BIT 5
`define PMC_LDO3_PASS_BIT 6
`define PMC_LDO1_EN_BIT 8
`define PMC_LDO2_EN_BIT 9
`define PMC_LDO3_EN_BIT 10
`define PMC_LDO_MASK 32'h0000077F
`define PMC_LDO_RESET 32'h00000000

// Charger control word layout.
`define PMC_VCHG_LSB 0
`define PMC_ICHG_LSB 4
`define PMC_TRICKLE_BIT 8
`define PMC_THERM_DIS_BIT 9
`define PMC_OVRD_BIT 10
`define PMC_SWCTL_BIT 11
`define PMC_REV_BIT 12
`define PMC_POWER_LIMIT_SETTING_LSB 13
`define PMC_POWER_LIMIT_SETTING_DIS_BIT 15
`define PMC_LED_EN_BIT 16
`define PMC_MODE_BIT 17
`define PMC_SP_OVRD_BIT 18
`define PMC_CYCL_DIS_BIT 19
`define PMC_CHG_MASK 32'h000FFFFF
`define PMC_CHG_RESET 32'h00000003

// Command word: writing 1 restarts the charger state machine.
`define PMC_RESTART_BIT 0

// Status word layout.
`define PMC_ST_SHORT_BIT 0
`define PMC_ST_LDO3_ON_BIT 1
`define PMC_ST_SWITCH_BIT 2
`define PMC_ST_OVP_BIT 3

`define PMC_ICHG_OFF 4'h0
`define PMC_ICHG_FULL 4'hF

`endif

// ---- pmc_pkg.sv ----
// Types shared by the regulator and charger control block.
// Assumes pmc_params.svh is on the include path.
package pmc_pkg;
`include "pmc_params.svh"

   typedef enum logic [1:0] {
      PMC_AHB_IDLE = 2'b00,
      PMC_AHB_BUSY = 2'b01,
      PMC_AHB_NONSEQ = 2'b10,
      PMC_AHB_SEQ = 2'b11
   } pmc_htrans_t;

   typedef enum logic [0:0] {
      PMC_PASS_INTERNAL = 1'b0,
      PMC_PASS_EXTERNAL = 1'b1
   } pmc_pass_t;

endpackage

// ---- pmc_ldo_charger_ctrl.sv ----
// Regulator set-point and charger control registers, AHB-Lite slave.
// Assumes a single 100 MHz clock, synchronous active-high reset, and
// analog status inputs already synchronous to ref_clk.
//
// Behaviour
// - Regulator one set-point: 2-bit code, 1.20/1.50/2.775/3.15 V.
// - Regulator two set-point: 3-bit code, eight ascending voltages.
// - Regulator three set-point bit: 0 gives 1.80 V, 1 gives 2.90 V.
// - Regulator three pass select: 0 internal, 1 external transistor.
// - Regulator three stays off after power-up until software enables it.
// - Short on regulator three turns it off and raises interrupt event.
// - Serial path, dead battery: switch open while trickling, closed later.
// - Charger overvoltage turns both charge-path transistors off.
// - Host programs 3-bit charge voltage and 4-bit charge current.
// - Trickle enable bit switches the trickle charger on.
// - Thermistor-check disable bit suppresses the thermistor check.
// - Override 0: hardware drives switch; 1: software bit drives it.
// - With override set, software 0 drives output high, 1 drives low.
// - Reverse mode bit: 1 forces the charge path on except in overvoltage, and closes the switch when override is 0.
// - 2-bit power-limit setting; limiter disable bit 1 turns it off.
// - Charge indicator enable: 0 LED off, 1 LED allowed.
// - Writing restart pulses the charger state machine restart.
// - Mode select: 0 standalone charging, 1 software charging.
// - Override bit lets host set-points apply in standalone mode.
// - Cycling disable: 0 enables charge cycling, 1 disables it.
// - Charge voltage resets to code 011 (4.200 V).
// - Current 0000 means off, 1111 fully on with switch open.
`timescale 1ns/100ps
`include "pmc_params.svh"

module pmc_ldo_charger_ctrl
   import pmc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic ldoThreeShort,
   input wire logic chargerOverVoltage,
   input wire logic serialPath,
   input wire logic batteryCharged,
   input wire logic chargeActive,
   input wire logic wall_charger_detect_in_n,
   output logic [1:0] general_ldo_one,
   output logic [2:0] general_ldo_two,
   output logic general_ldo_three,
   output logic ldo_three_pass_select,
   output logic ldoOneEnable,
   output logic ldoTwoEnable,
   output logic ldoThreeEnable,
   output logic short_circuit_irq,
   output logic battery_switch_output,
   output logic chargePathOn,
   output logic [2:0] charge_voltage_setpoint,
   output logic [3:0] charge_current_setpoint,
   output logic trickle_enable,
   output logic thermistor_check_disable,
   output logic reverse_supply_enable,
   output logic [1:0] power_limit_setting,
   output logic power_limit_disable,
   output logic charge_indicator_output,
   output logic charger_fsm_restart,
   output logic charging_mode_select,
   output logic standalone_setpoint_override,
   output logic cycling_disable,
   output logic setpointsFromHost,
   output logic unregulatedCharger
);

   ////////////////////////////////////////////////////////////////////////
   // Bus address phase capture.

   logic wrPend;
   logic rdPend;
   logic [11:0] dataAddr;
   logic [31:0] ldoReg;
   logic [31:0] chgReg;
   logic shortSeen;
   logic hwSwitch;

   wire addrValid = hsel && hready && htrans[1];
   wire wrLdo = wrPend && (dataAddr == `PMC_OFF_LDO);
   wire wrChg = wrPend && (dataAddr == `PMC_OFF_CHG);
   wire wrCmd = wrPend && (dataAddr == `PMC_OFF_CMD);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wrPend <= 1'b0;
         rdPend <= 1'b0;
         dataAddr <= 12'h000;
      end else begin
         wrPend <= addrValid && hwrite;
         rdPend <= addrValid && !hwrite;
         dataAddr <= addrValid ? {haddr[11:2], 2'b00} : dataAddr;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // Control registers; each field except the regulator three enable, which a short clears, keeps its last write until reset.

   // A short on regulator three clears its enable in the same cycle,
   // winning over a software write that tries to turn it on.
   wire [31:0] ldoWrite = hwdata & `PMC_LDO_MASK;
   wire [31:0] ldoAfterWr = wrLdo ? ldoWrite : ldoReg;
   wire [31:0] ldoShortClr = ~(32'h1 << `PMC_LDO3_EN_BIT);
   wire [31:0] next_ldoReg = ldoThreeShort ? (ldoAfterWr & ldoShortClr)
                                           : ldoAfterWr;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ldoReg <= `PMC_LDO_RESET;
         chgReg <= `PMC_CHG_RESET;
      end else begin
         ldoReg <= next_ldoReg;
         chgReg <= wrChg ? (hwdata & `PMC_CHG_MASK) : chgReg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Restart pulse and sticky short event; a new short wins over clear.

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         charger_fsm_restart <= 1'b0;
         shortSeen <= 1'b0;
      end else begin
         charger_fsm_restart <= wrCmd && hwdata[`PMC_RESTART_BIT];
         if (ldoThreeShort) begin
            shortSeen <= 1'b1;
         end else if (wrCmd && hwdata[`PMC_ST_SHORT_BIT + 1]) begin
            shortSeen <= 1'b0;
         end
      end
   end

   assign short_circuit_irq = shortSeen;

   ////////////////////////////////////////////////////////////////////////
   // Regulator field outputs.

   assign general_ldo_one = ldoReg[`PMC_LDO1_LSB +: 2];
   assign general_ldo_two = ldoReg[`PMC_LDO2_LSB +: 3];
   assign general_ldo_three = ldoReg[`PMC_LDO3_BIT];
   assign ldo_three_pass_select = ldoReg[`PMC_LDO3_PASS_BIT];
   assign ldoOneEnable = ldoReg[`PMC_LDO1_EN_BIT];
   assign ldoTwoEnable = ldoReg[`PMC_LDO2_EN_BIT];
   assign ldoThreeEnable = ldoReg[`PMC_LDO3_EN_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Charger field outputs.

   assign charge_voltage_setpoint = chgReg[`PMC_VCHG_LSB +: 3];
   assign charge_current_setpoint = chgReg[`PMC_ICHG_LSB +: 4];
   assign trickle_enable = chgReg[`PMC_TRICKLE_BIT];
   assign thermistor_check_disable = chgReg[`PMC_THERM_DIS_BIT];
   assign reverse_supply_enable = chgReg[`PMC_REV_BIT];
   assign power_limit_setting = chgReg[`PMC_POWER_LIMIT_SETTING_LSB +: 2];
   assign power_limit_disable = chgReg[`PMC_POWER_LIMIT_SETTING_DIS_BIT];
   assign charging_mode_select = chgReg[`PMC_MODE_BIT];
   assign standalone_setpoint_override = chgReg[`PMC_SP_OVRD_BIT];
   assign cycling_disable = chgReg[`PMC_CYCL_DIS_BIT];

   // Host set-points apply in software mode, or in standalone mode
   // when the override bit is set.
   assign setpointsFromHost = charging_mode_select
                              || standalone_setpoint_override;

   // The pin is low when an unregulated wall charger is fitted.
   assign unregulatedCharger = !wall_charger_detect_in_n;

   ////////////////////////////////////////////////////////////////////////
   // Charge path and battery switch.

   wire swOverride = chgReg[`PMC_OVRD_BIT];
   wire swControl = chgReg[`PMC_SWCTL_BIT];
   wire currentOff = charge_current_setpoint == `PMC_ICHG_OFF;
   wire currentFull = charge_current_setpoint == `PMC_ICHG_FULL;
   wire deadBattTrickle = serialPath && !batteryCharged;

   // Active-low output closes the switch; high means open here,
   // matching the software override polarity of the switch pin.
   always_comb begin
      if (reverse_supply_enable) begin
         hwSwitch = 1'b0;
      end else if (currentFull) begin
         hwSwitch = 1'b1;
      end else if (deadBattTrickle) begin
         hwSwitch = 1'b1;
      end else begin
         hwSwitch = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         battery_switch_output <= 1'b0;
         chargePathOn <= 1'b0;
         charge_indicator_output <= 1'b0;
      end else begin
         battery_switch_output <= swOverride ? !swControl
                                             : hwSwitch;
         chargePathOn <= !chargerOverVoltage
                         && (reverse_supply_enable || !currentOff);
         charge_indicator_output <= chgReg[`PMC_LED_EN_BIT]
                                    && chargeActive;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data.

   wire [31:0] statWord = {28'h0000000, chargerOverVoltage,
                           battery_switch_output, ldoThreeEnable,
                           shortSeen};
   wire [31:0] rdMux = (dataAddr == `PMC_OFF_LDO) ? ldoReg :
                       (dataAddr == `PMC_OFF_CHG) ? chgReg :
                       (dataAddr == `PMC_OFF_STAT) ? statWord : 32'h00000000;

   assign hrdata = rdPend ? rdMux : 32'h00000000;

endmodule

// ---- pmc_ldo_charger_ctrl_assertions.sv ----
// Port-level checks for the regulator and charger control block.
// Bound from the bench top; one clock, synchronous reset.
`timescale 1ns/100ps
module pmc_ldo_charger_ctrl_assertions (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ldoThreeShort,
   input wire logic ldoThreeEnable,
   input wire logic short_circuit_irq,
   input wire logic chargerOverVoltage,
   input wire logic chargePathOn,
   input wire logic reverse_supply_enable,
   input wire logic wall_charger_detect_in_n,
   input wire logic unregulatedCharger,
   input wire logic charging_mode_select,
   input wire logic standalone_setpoint_override,
   input wire logic setpointsFromHost,
   input wire logic charger_fsm_restart,
   input wire logic [2:0] charge_voltage_setpoint
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_short;
      ldoThreeShort;
   endsequence
   sequence s_dropped;
      !ldoThreeEnable && short_circuit_irq;
   endsequence
   a_short_kills_ldo: assert property (s_short |=> s_dropped)
      else $error("regulator three kept on after short");
   a_irq_has_cause: assert property
      ($rose(short_circuit_irq) |-> $past(ldoThreeShort))
      else $error("short event raised without a short");
   a_ovp_path_off: assert property
      (chargerOverVoltage[*2] |-> !chargePathOn)
      else $error("charge path on during overvoltage");
   a_reverse_path_on: assert property
      (!chargerOverVoltage && reverse_supply_enable |=> chargePathOn)
      else $error("charge path off in reverse mode");
   a_wall_detect: assert property
      (unregulatedCharger == !wall_charger_detect_in_n)
      else $error("wall charger detect wrong");
   a_host_setpoints: assert property
      (setpointsFromHost == (charging_mode_select ||
       standalone_setpoint_override))
      else $error("host set-point select wrong");
   a_restart_pulse: assert property
      (charger_fsm_restart |=> !charger_fsm_restart)
      else $error("restart longer than one cycle");
   a_ldo3_off_boot: assert property ($fell(rst) |-> !ldoThreeEnable)
      else $error("regulator three on after reset");
   a_vchg_default: assert property
      ($fell(rst) |-> charge_voltage_setpoint == 3'h3)
      else $error("charge voltage reset code wrong");
endmodule

// ---- pmc_ahb_host.sv ----
// Bus master standing in for the host that programs the block.
// Assumes hready is the slave's hreadyout; single word transfers only.
`timescale 1ns/100ps
module pmc_ahb_host
   import pmc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [11:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   initial begin
      hsel = 1'b1;
      haddr = 12'h000;
      htrans = PMC_AHB_IDLE;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
   end
   // Holds each phase until hready is sampled high; stale data is inverted.
   task automatic xfer(input logic wr, input logic [11:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge ref_clk);
      haddr <= a;
      hwrite <= wr;
      htrans <= PMC_AHB_NONSEQ;
      do @(posedge ref_clk); while (hready !== 1'b1);
      htrans <= PMC_AHB_IDLE;
      hwdata <= wd;
      do @(posedge ref_clk); while (hready !== 1'b1);
      rd = hrdata;
      hwdata <= ~wd;
   endtask
endmodule

// ---- pmc_ldo_charger_ctrl_tb_top.sv ----
// Bench top: programs the block over its bus and checks its pins.
// Assumes the host model and checker are compiled before this file.
`timescale 1ns/100ps
`include "pmc_params.svh"
module pmc_ldo_charger_ctrl_tb_top;
   logic ref_clk, rst, hsel, hwrite, hreadyout, b;
   logic [11:0] haddr;
   logic [1:0] htrans, general_ldo_one, power_limit_setting;
   logic [2:0] hsize, general_ldo_two, charge_voltage_setpoint;
   logic [3:0] charge_current_setpoint;
   logic [31:0] hwdata, hrdata, w;
   logic ldoThreeShort, chargerOverVoltage, serialPath, batteryCharged;
   logic chargeActive, wall_charger_detect_in_n, general_ldo_three;
   logic ldo_three_pass_select, ldoOneEnable, ldoTwoEnable, ldoThreeEnable;
   logic short_circuit_irq, battery_switch_output, chargePathOn;
   logic trickle_enable, thermistor_check_disable, reverse_supply_enable;
   logic power_limit_disable, charge_indicator_output, charger_fsm_restart;
   logic charging_mode_select, standalone_setpoint_override;
   logic cycling_disable, setpointsFromHost, unregulatedCharger;
   int n_fail = 0, num_checks = 0, n;
   pmc_ahb_host u_host (.ref_clk, .hready(hreadyout), .hrdata, .hsel,
      .haddr, .htrans, .hwrite, .hsize, .hwdata);
   pmc_ldo_charger_ctrl u_dut (.ref_clk, .rst, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
      .hresp(), .ldoThreeShort, .chargerOverVoltage, .serialPath,
      .batteryCharged, .chargeActive, .wall_charger_detect_in_n,
      .general_ldo_one, .general_ldo_two, .general_ldo_three,
      .ldo_three_pass_select, .ldoOneEnable, .ldoTwoEnable, .ldoThreeEnable,
      .short_circuit_irq, .battery_switch_output, .chargePathOn,
      .charge_voltage_setpoint, .charge_current_setpoint, .trickle_enable,
      .thermistor_check_disable, .reverse_supply_enable,
      .power_limit_setting, .power_limit_disable, .charge_indicator_output,
      .charger_fsm_restart, .charging_mode_select,
      .standalone_setpoint_override, .cycling_disable, .setpointsFromHost,
      .unregulatedCharger);
   task automatic chk(string s, logic [31:0] g, logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic wr(logic [11:0] a, logic [31:0] d);
      logic [31:0] r;
      u_host.xfer(1'b1, a, d, r);
   endtask
   task automatic rd_chk(logic [11:0] a, logic [31:0] e);
      logic [31:0] r;
      u_host.xfer(1'b0, a, 32'h00000000, r);
      chk("read", r, e);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      tally_and_finish;
   end
   initial begin
      rst = 1'b1;
      ldoThreeShort = 1'b0;
      chargerOverVoltage = 1'b0;
      serialPath = 1'b1;
      batteryCharged = 1'b0;
      chargeActive = 1'b0;
      wall_charger_detect_in_n = 1'b1;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      rd_chk(`PMC_OFF_LDO, 32'h00000000);
      rd_chk(`PMC_OFF_CHG, 32'h00000003);
      for (int i = 0; i < 8; i++) begin
         w = {21'h0, 3'h7, 1'b0, ~i[0], i[0], i[2:0], i[1:0]};
         wr(`PMC_OFF_LDO, w);
         rd_chk(`PMC_OFF_LDO, w);
         chk("ldo", {general_ldo_one, general_ldo_two, general_ldo_three,
            ldo_three_pass_select, ldoOneEnable, ldoTwoEnable,
            ldoThreeEnable}, {i[1:0], i[2:0], i[0], ~i[0], 3'h7});
      end
      for (int c = 0; c < 16; c++) begin
         batteryCharged <= c[3];
         chargeActive <= c[3];
         wall_charger_detect_in_n <= c[0];
         w = (c * 32'h00011111) & 32'h000FFFF7;
         wr(`PMC_OFF_CHG, w);
         rd_chk(`PMC_OFF_CHG, w);
         chk("setpoints", {charge_voltage_setpoint, charge_current_setpoint},
            {c[2:0], c[3:0]});
         chk("fields", {trickle_enable, thermistor_check_disable,
            reverse_supply_enable, power_limit_setting, power_limit_disable,
            charging_mode_select, standalone_setpoint_override,
            cycling_disable}, {c[0], c[1], c[0], c[2:1], c[3], c[1], c[2],
            c[3]});
         b = c[2] ? !c[3] : !c[0] && (c == 15 || !c[3]);
         chk("switch", battery_switch_output, b);
         chk("led", charge_indicator_output, c[0] & c[3]);
         chk("path", chargePathOn, c != 0);
      end
      chargerOverVoltage <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk("overvoltage", chargePathOn, 1'b0);
      chargerOverVoltage <= 1'b0;
      ldoThreeShort <= 1'b1;
      @(posedge ref_clk);
      ldoThreeShort <= 1'b0;
      rd_chk(`PMC_OFF_STAT, 32'h00000001);
      wr(`PMC_OFF_CMD, 32'h00000002);
      rd_chk(`PMC_OFF_STAT, 32'h00000000);
      wr(`PMC_OFF_CMD, 32'h00000001);
      n = 0;
      repeat (4) begin
         @(posedge ref_clk);
         n += charger_fsm_restart;
      end
      chk("restart", 32'(n), 32'h00000001);
      wr(12'h010, 32'hFFFFFFFF);
      rd_chk(12'h010, 32'h00000000);
      rd_chk(`PMC_OFF_LDO, 32'h0000033F);
      tally_and_finish;
   end
endmodule
bind pmc_ldo_charger_ctrl pmc_ldo_charger_ctrl_assertions u_chk (.ref_clk,
   .rst, .ldoThreeShort, .ldoThreeEnable, .short_circuit_irq,
   .chargerOverVoltage, .chargePathOn, .reverse_supply_enable,
   .wall_charger_detect_in_n, .unregulatedCharger, .charging_mode_select,
   .standalone_setpoint_override, .setpointsFromHost, .charger_fsm_restart,
   .charge_voltage_setpoint);
